// ---- eau_mem.sv ----
// Program and data memory model that answers the unit's byte reads.
`timescale 1ns/1ps
`default_nettype none

module eau_mem (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Read port.
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	// Wait states before each answer.
	input wire logic [1:0] lat
);
	logic [7:0] m [0:65535];
	logic [1:0] cnt;

	// Outside an answer the data lines toggle, so stale bytes are never mistaken for data.
	always_ff @(posedge clk) begin
		if (reset) begin
			mem_ack <= 1'b0;
			cnt <= 2'h0;
			mem_rdata <= 8'h00;
		end else if (mem_rd && !mem_ack && cnt >= lat) begin
			mem_ack <= 1'b1;
			mem_rdata <= m[mem_addr];
			cnt <= 2'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt <= cnt + 2'(mem_rd && !mem_ack);
		end
	end
endmodule // eau_mem

`default_nettype wire

// ---- eau_pkg.sv ----
// Package with constants, modes, states and carriers of the effective-address unit.
package eau_pkg;

	// Addressing modes requested by the instruction sequencer.
	typedef enum logic [1:0] {
		EAU_MODE_EXTENDED = 2'h0,
		EAU_MODE_DIRECT = 2'h1,
		EAU_MODE_REGISTER = 2'h2,
		EAU_MODE_INDEXED = 2'h3
	} eau_mode_e;

	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		EAU_ST_IDLE = 4'h1,
		EAU_ST_FETCH = 4'h2,
		EAU_ST_CALC = 4'h4,
		EAU_ST_IND = 4'h8
	} eau_state_e;

	// Postbyte field positions.
	localparam int EAU_PB_FORM_BIT = 7;
	localparam int EAU_PB_RR_MSB = 6;
	localparam int EAU_PB_RR_LSB = 5;
	localparam int EAU_PB_IND_BIT = 4;
	localparam int EAU_PB_OFF5_MSB = 4;

	// Pointer select codes.
	localparam logic [1:0] EAU_RR_FIRST_INDEX = 2'h0;
	localparam logic [1:0] EAU_RR_SECOND_INDEX = 2'h1;
	localparam logic [1:0] EAU_RR_USER_STACK = 2'h2;
	localparam logic [1:0] EAU_RR_HW_STACK = 2'h3;

	// Low-nibble forms of a postbyte with bit 7 set.
	localparam logic [3:0] EAU_F_INC1 = 4'h0;
	localparam logic [3:0] EAU_F_INC2 = 4'h1;
	localparam logic [3:0] EAU_F_DEC1 = 4'h2;
	localparam logic [3:0] EAU_F_DEC2 = 4'h3;
	localparam logic [3:0] EAU_F_ZERO = 4'h4;
	localparam logic [3:0] EAU_F_ACC_LOW = 4'h5;
	localparam logic [3:0] EAU_F_ACC_HIGH = 4'h6;
	localparam logic [3:0] EAU_F_OFF8 = 4'h8;
	localparam logic [3:0] EAU_F_OFF16 = 4'h9;
	localparam logic [3:0] EAU_F_ACC_DOUBLE = 4'hB;
	localparam logic [3:0] EAU_F_PC8 = 4'hC;
	localparam logic [3:0] EAU_F_PC16 = 4'hD;
	localparam logic [3:0] EAU_F_EXT_IND = 4'hF;

	// Additional cycles of the non-indirect forms; indirect adds EAU_CYC_IND_ADD, except extended indirect, which uses EAU_CYC_EXT_IND alone.
	localparam logic [3:0] EAU_CYC_INC1 = 4'h2;
	localparam logic [3:0] EAU_CYC_INC2 = 4'h3;
	localparam logic [3:0] EAU_CYC_ZERO = 4'h0;
	localparam logic [3:0] EAU_CYC_ONE = 4'h1;
	localparam logic [3:0] EAU_CYC_FOUR = 4'h4;
	localparam logic [3:0] EAU_CYC_PC16 = 4'h5;
	localparam logic [3:0] EAU_CYC_IND_ADD = 4'h3;
	localparam logic [3:0] EAU_CYC_EXT_IND = 4'h5;

	// Reset values.
	localparam logic [7:0] EAU_PAGE_BASE_RESET = 8'h00;
	localparam logic [15:0] EAU_ADDR_RESET = 16'h0000;

	// Register values handed over with a request.
	typedef struct packed {
		logic [15:0] first_index;
		logic [15:0] second_index;
		logic [15:0] user_stack;
		logic [15:0] hw_stack;
		logic [7:0] accumulator_high;
		logic [7:0] accumulator_low;
	} eau_ptrs_s;

	// Result handed back when the address is ready.
	typedef struct packed {
		logic [15:0] effective_address;
		logic [7:0] register_selector;
		logic [3:0] extra_cycles;
		logic [1:0] extra_bytes;
		logic undefined;
		logic ptr_write;
		logic [1:0] ptr_select;
		logic [15:0] ptr_value;
	} eau_result_s;

endpackage

// ---- eau_unit.sv ----
// Effective-address unit: fetches operand bytes and forms the operand address.
// Notes on behaviour
// RL1 - Extended: two bytes form absolute address.
// RL2 - Extended indirect: read address from memory.
// RL3 - Direct: one byte gives low address.
// RL4 - Direct: high byte from page base.
// RL5 - Reset clears page base to zero.
// RL6 - Register mode: next byte selects registers.
// RL7 - Indexed postbyte chooses type, variant, pointer.
// RL8 - Pointer field selects index, index, user, hardware.
// RL9 - Zero offset uses pointer directly.
// RL10 - Constant offset sign-extends, pointer stays unchanged.
// RL11 - Bit 7 clear: 5-bit offset, no indirect.
// RL12 - 8-bit offset from one following byte.
// RL13 - 16-bit offset from two following bytes.
// RL14 - Accumulator high or low as signed offset.
// RL15 - Double accumulator offset, nothing altered.
// RL16 - Post-increment, pre-decrement by one or two.
// RL17 - Program counter usable as offset base.
// RL18 - Indirect reads two bytes, high first.
// RL19 - Undefined postbytes flagged, result unspecified.
`timescale 1ns/1ps
`default_nettype none

module eau_unit
	import eau_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Request from the instruction sequencer.
	input wire logic start,
	input wire eau_mode_e mode,
	input wire logic [15:0] operand_addr,
	input wire eau_ptrs_s ptrs,
	// Page base load from the register transfer logic.
	input wire logic page_base_load,
	input wire logic [7:0] page_base_value,
	// Program and data memory read port.
	output logic mem_rd,
	output logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Result.
	output logic busy,
	output logic done,
	output eau_result_s result,
	output logic [7:0] page_base_register
);

	eau_state_e state_reg, state_next;
	eau_mode_e mode_reg, mode_next;
	eau_ptrs_s ptrs_reg, ptrs_next;
	eau_result_s result_reg, result_next;
	logic [15:0] fetch_addr_reg, fetch_addr_next;
	logic [15:0] buf_reg, buf_next;
	logic [7:0] post_reg, post_next;
	logic [1:0] need_reg, need_next;
	logic got_post_reg, got_post_next;
	logic rd_reg, rd_next;
	logic [15:0] addr_reg, addr_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic [7:0] page_base_reg, page_base_next;

	// Decode of the captured postbyte.
	logic [15:0] ptr;
	logic [15:0] ea_calc;
	logic [15:0] wb_value;
	logic wb_en;
	logic ind;
	logic undef;
	logic [3:0] cyc;
	logic [3:0] form;
	logic [1:0] rr;

	always_comb begin
		rr = post_reg[EAU_PB_RR_MSB:EAU_PB_RR_LSB];
		form = post_reg[3:0];
		ind = post_reg[EAU_PB_FORM_BIT] & post_reg[EAU_PB_IND_BIT];
		case (rr) // RL8
			EAU_RR_FIRST_INDEX: ptr = ptrs_reg.first_index;
			EAU_RR_SECOND_INDEX: ptr = ptrs_reg.second_index;
			EAU_RR_USER_STACK: ptr = ptrs_reg.user_stack;
			default: ptr = ptrs_reg.hw_stack;
		endcase
		ea_calc = EAU_ADDR_RESET;
		wb_value = ptr;
		wb_en = 1'b0;
		undef = 1'b0;
		cyc = EAU_CYC_ZERO;
		if (!post_reg[EAU_PB_FORM_BIT]) begin
			// Offset inside the postbyte; the indirect bit is part of the offset here.
			ea_calc = ptr + {{11{post_reg[EAU_PB_OFF5_MSB]}}, post_reg[4:0]}; // RL11 RL10
			cyc = EAU_CYC_ONE;
		end else begin
			case (form) // RL7
				EAU_F_INC1: begin
					ea_calc = ptr; // RL16
					wb_value = ptr + 16'h0001;
					wb_en = 1'b1;
					cyc = EAU_CYC_INC1;
					undef = ind;
				end
				EAU_F_INC2: begin
					ea_calc = ptr; // RL16
					wb_value = ptr + 16'h0002;
					wb_en = 1'b1;
					cyc = EAU_CYC_INC2;
				end
				EAU_F_DEC1: begin
					ea_calc = ptr - 16'h0001; // RL16
					wb_value = ptr - 16'h0001;
					wb_en = 1'b1;
					cyc = EAU_CYC_INC1;
					undef = ind;
				end
				EAU_F_DEC2: begin
					ea_calc = ptr - 16'h0002; // RL16
					wb_value = ptr - 16'h0002;
					wb_en = 1'b1;
					cyc = EAU_CYC_INC2;
				end
				EAU_F_ZERO: ea_calc = ptr; // RL9
				EAU_F_ACC_LOW: begin
					ea_calc = ptr + {{8{ptrs_reg.accumulator_low[7]}}, ptrs_reg.accumulator_low}; // RL14
					cyc = EAU_CYC_ONE;
				end
				EAU_F_ACC_HIGH: begin
					ea_calc = ptr + {{8{ptrs_reg.accumulator_high[7]}}, ptrs_reg.accumulator_high}; // RL14
					cyc = EAU_CYC_ONE;
				end
				EAU_F_OFF8: begin
					ea_calc = ptr + {{8{buf_reg[7]}}, buf_reg[7:0]}; // RL12 RL10
					cyc = EAU_CYC_ONE;
				end
				EAU_F_OFF16: begin
					ea_calc = ptr + buf_reg; // RL13 RL10
					cyc = EAU_CYC_FOUR;
				end
				EAU_F_ACC_DOUBLE: begin
					ea_calc = ptr + {ptrs_reg.accumulator_high, ptrs_reg.accumulator_low}; // RL15
					cyc = EAU_CYC_FOUR;
				end
				EAU_F_PC8: begin
					// The program counter already points past the offset byte.
					ea_calc = fetch_addr_reg + {{8{buf_reg[7]}}, buf_reg[7:0]}; // RL17
					cyc = EAU_CYC_ONE;
				end
				EAU_F_PC16: begin
					ea_calc = fetch_addr_reg + buf_reg; // RL17
					cyc = EAU_CYC_PC16;
				end
				EAU_F_EXT_IND: begin
					ea_calc = buf_reg; // RL2
					cyc = EAU_CYC_EXT_IND;
					undef = !(ind && rr == EAU_RR_FIRST_INDEX);
				end
				default: begin
					undef = 1'b1; // RL19
				end
			endcase
			if (ind && form != EAU_F_EXT_IND) begin
				cyc = cyc + EAU_CYC_IND_ADD;
			end
		end
	end

	// Next-state logic of the sequencer.
	always_comb begin
		state_next = state_reg;
		mode_next = mode_reg;
		ptrs_next = ptrs_reg;
		result_next = result_reg;
		fetch_addr_next = fetch_addr_reg;
		buf_next = buf_reg;
		post_next = post_reg;
		need_next = need_reg;
		got_post_next = got_post_reg;
		rd_next = rd_reg;
		addr_next = addr_reg;
		done_next = 1'b0;
		page_base_next = page_base_reg;
		if (page_base_load) begin
			page_base_next = page_base_value;
		end
		case (state_reg)
			EAU_ST_IDLE: begin
				if (start) begin
					mode_next = mode;
					ptrs_next = ptrs;
					fetch_addr_next = operand_addr;
					addr_next = operand_addr;
					rd_next = 1'b1;
					got_post_next = 1'b0;
					need_next = (mode == EAU_MODE_EXTENDED) ? 2'h2 : 2'h1; // RL1 RL3
					result_next = '0;
					state_next = EAU_ST_FETCH;
				end
			end
			EAU_ST_FETCH: begin
				if (rd_reg && mem_ack) begin
					fetch_addr_next = fetch_addr_reg + 16'h0001;
					addr_next = fetch_addr_reg + 16'h0001;
					if (mode_reg == EAU_MODE_INDEXED && !got_post_reg) begin
						post_next = mem_rdata;
						got_post_next = 1'b1;
						need_next = need_from_form(mem_rdata); // RL7
					end else begin
						buf_next = {buf_reg[7:0], mem_rdata}; // RL1
						need_next = need_reg - 2'h1;
					end
					if (need_next == 2'h0) begin
						rd_next = 1'b0;
						state_next = EAU_ST_CALC;
					end
				end
			end
			EAU_ST_CALC: begin
				case (mode_reg)
					EAU_MODE_EXTENDED: begin
						result_next.effective_address = buf_reg; // RL1
						result_next.extra_bytes = 2'h2;
						done_next = 1'b1;
						state_next = EAU_ST_IDLE;
					end
					EAU_MODE_DIRECT: begin
						result_next.effective_address = {page_base_reg, buf_reg[7:0]}; // RL3 RL4
						result_next.extra_bytes = 2'h1;
						done_next = 1'b1;
						state_next = EAU_ST_IDLE;
					end
					EAU_MODE_REGISTER: begin
						result_next.register_selector = buf_reg[7:0]; // RL6
						result_next.extra_bytes = 2'h1;
						done_next = 1'b1;
						state_next = EAU_ST_IDLE;
					end
					default: begin
						result_next.extra_cycles = cyc;
						result_next.extra_bytes = need_from_form(post_reg);
						result_next.undefined = undef; // RL19
						result_next.ptr_write = wb_en && !undef; // RL16
						result_next.ptr_select = rr;
						result_next.ptr_value = wb_value;
						result_next.effective_address = ea_calc;
						if (ind && !undef) begin
							addr_next = ea_calc; // RL18
							rd_next = 1'b1;
							need_next = 2'h2;
							state_next = EAU_ST_IND;
						end else begin
							done_next = 1'b1;
							state_next = EAU_ST_IDLE;
						end
					end
				endcase
			end
			EAU_ST_IND: begin
				if (rd_reg && mem_ack) begin
					buf_next = {buf_reg[7:0], mem_rdata}; // RL18
					need_next = need_reg - 2'h1;
					addr_next = addr_reg + 16'h0001;
					if (need_reg == 2'h1) begin
						rd_next = 1'b0;
						result_next.effective_address = {buf_reg[7:0], mem_rdata}; // RL18 RL2
						done_next = 1'b1;
						state_next = EAU_ST_IDLE;
					end
				end
			end
			default: begin
				rd_next = 1'b0;
				state_next = EAU_ST_IDLE;
			end
		endcase
		busy_next = (state_next != EAU_ST_IDLE);
	end

	// Bytes that follow the postbyte for a given postbyte.
	function automatic logic [1:0] need_from_form(input logic [7:0] pb);
		logic [1:0] n;
		n = 2'h0;
		if (pb[EAU_PB_FORM_BIT]) begin
			if (pb[3:0] == EAU_F_OFF8 || pb[3:0] == EAU_F_PC8) begin
				n = 2'h1;
			end else if (pb[3:0] == EAU_F_OFF16 || pb[3:0] == EAU_F_PC16 ||
				pb[3:0] == EAU_F_EXT_IND) begin
				n = 2'h2;
			end
		end
		return n;
	endfunction

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= EAU_ST_IDLE;
			mode_reg <= EAU_MODE_EXTENDED;
			ptrs_reg <= '0;
			result_reg <= '0;
			fetch_addr_reg <= EAU_ADDR_RESET;
			buf_reg <= EAU_ADDR_RESET;
			post_reg <= 8'h00;
			need_reg <= 2'h0;
			got_post_reg <= 1'b0;
			rd_reg <= 1'b0;
			addr_reg <= EAU_ADDR_RESET;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			page_base_reg <= EAU_PAGE_BASE_RESET; // RL5
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			ptrs_reg <= ptrs_next;
			result_reg <= result_next;
			fetch_addr_reg <= fetch_addr_next;
			buf_reg <= buf_next;
			post_reg <= post_next;
			need_reg <= need_next;
			got_post_reg <= got_post_next;
			rd_reg <= rd_next;
			addr_reg <= addr_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			page_base_reg <= page_base_next;
		end
	end

	assign mem_rd = rd_reg;
	assign mem_addr = addr_reg;
	assign busy = busy_reg;
	assign done = done_reg;
	assign result = result_reg;
	assign page_base_register = page_base_reg;

endmodule // eau_unit

`default_nettype wire

// ---- eau_unit_sva.sv ----
// Checker of the effective-address unit's port behaviour.
`timescale 1ns/1ps
`default_nettype none

module eau_unit_sva
	import eau_pkg::*;
(
	// Watched ports.
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire eau_mode_e mode,
	input wire logic [15:0] operand_addr,
	input wire logic page_base_load,
	input wire logic [7:0] page_base_value,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic busy,
	input wire logic done,
	input wire eau_result_s result,
	input wire logic [7:0] page_base_register
);
	AST_PB_RESET: assert property (@(posedge clk) reset |=> page_base_register == 8'h00)
		else $error("page base not cleared by reset");
	AST_PB_LOAD: assert property (@(posedge clk) disable iff (reset)
		page_base_load |=> page_base_register == $past(page_base_value))
		else $error("page base load lost");
	AST_RD_HOLD: assert property (@(posedge clk) disable iff (reset)
		mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
		else $error("read dropped before answer");
	AST_BUSY_START: assert property (@(posedge clk) disable iff (reset)
		start && !busy |=> busy && !done)
		else $error("start not taken");
	AST_DONE_PULSE: assert property (@(posedge clk) disable iff (reset)
		done |-> !busy ##1 !done)
		else $error("done not a single pulse");
	AST_EXT_FIRST: assert property (@(posedge clk) disable iff (reset)
		start && !busy && mode == EAU_MODE_EXTENDED
		|=> mem_rd && mem_addr == $past(operand_addr))
		else $error("extended read not at operand address");
	AST_BOUND: assert property (@(posedge clk) disable iff (reset)
		start && !busy |-> ##[1:60] done)
		else $error("request never completed");
	AST_UNDEF: assert property (@(posedge clk) disable iff (reset)
		done && result.undefined |-> !result.ptr_write && !mem_rd)
		else $error("undefined postbyte had side effects");
endmodule // eau_unit_sva

bind eau_unit eau_unit_sva u_sva (.clk(clk), .reset(reset), .start(start), .mode(mode),
	.operand_addr(operand_addr), .page_base_load(page_base_load),
	.page_base_value(page_base_value), .mem_rd(mem_rd), .mem_addr(mem_addr),
	.mem_ack(mem_ack), .busy(busy), .done(done), .result(result),
	.page_base_register(page_base_register));

`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench of the effective-address unit.
`timescale 1ns/1ps
`default_nettype none

module testbench
	import eau_pkg::*;
;
	logic clk, reset, start, page_base_load, mem_rd, mem_ack, busy, done;
	eau_mode_e mode;
	logic [15:0] operand_addr, mem_addr;
	logic [7:0] page_base_value, mem_rdata, page_base_register;
	logic [1:0] lat;
	eau_ptrs_s ptrs;
	eau_result_s result;
	int error_cnt, comparisons;

	eau_unit dut (.clk(clk), .reset(reset), .start(start), .mode(mode),
		.operand_addr(operand_addr), .ptrs(ptrs), .page_base_load(page_base_load),
		.page_base_value(page_base_value), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
		.result(result), .page_base_register(page_base_register));
	eau_mem mem (.clk(clk), .reset(reset), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task final_report;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// One request, then a bounded wait for the done pulse.
	task go(input eau_mode_e m, input logic [15:0] a);
		@(posedge clk);
		#1 start = 1'b1;
		mode = m;
		operand_addr = a;
		@(posedge clk);
		#1 start = 1'b0;
		for (int i = 0; i < 100 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("done", 1, done);
	endtask

	task t_direct;
		mem.m[16'h0200] = 8'h56;
		chk("pb_reset", 8'h00, page_base_register);
		go(EAU_MODE_DIRECT, 16'h0200);
		chk("direct_ea", 16'h0056, result.effective_address);
		@(posedge clk);
		#1 page_base_load = 1'b1;
		page_base_value = 8'hA5;
		@(posedge clk);
		#1 page_base_load = 1'b0;
		lat = 2'h3;
		go(EAU_MODE_DIRECT, 16'h0200);
		chk("paged_ea", 16'hA556, result.effective_address);
		reset = 1'b1;
		@(posedge clk);
		#1 reset = 1'b0;
		chk("pb_rerst", 8'h00, page_base_register);
	endtask

	task t_ext_reg;
		mem.m[16'h0100] = 8'h12;
		mem.m[16'h0101] = 8'h34;
		go(EAU_MODE_EXTENDED, 16'h0100);
		chk("ext_ea", 16'h1234, result.effective_address);
		chk("ext_bytes", 2, result.extra_bytes);
		go(EAU_MODE_REGISTER, 16'h0101);
		chk("reg_sel", 8'h34, result.register_selector);
	endtask

	task idx(input logic [7:0] pb, input logic [7:0] b1, input logic [7:0] b2,
		input logic [15:0] ea, input logic [3:0] cy, input logic [1:0] eb, input logic pw);
		mem.m[16'h0300] = pb;
		mem.m[16'h0301] = b1;
		mem.m[16'h0302] = b2;
		lat = pb[2:1];
		go(EAU_MODE_INDEXED, 16'h0300);
		chk("idx_ea", ea, result.effective_address);
		chk("idx_cyc", cy, result.extra_cycles);
		chk("idx_bytes", eb, result.extra_bytes);
		chk("idx_pwr", pw, result.ptr_write);
	endtask

	task t_indexed;
		mem.m[16'h1000] = 8'hBE;
		mem.m[16'h1001] = 8'hEF;
		mem.m[16'h1200] = 8'hCA;
		mem.m[16'h1201] = 8'hFE;
		idx(8'h84, 8'h00, 8'h00, 16'h1000, 4'h0, 2'h0, 1'b0);
		idx(8'hA4, 8'h00, 8'h00, 16'h2000, 4'h0, 2'h0, 1'b0);
		chk("psel", 2'h1, result.ptr_select);
		idx(8'hC4, 8'h00, 8'h00, 16'h3000, 4'h0, 2'h0, 1'b0);
		idx(8'hE4, 8'h00, 8'h00, 16'h4000, 4'h0, 2'h0, 1'b0);
		idx(8'h1F, 8'h00, 8'h00, 16'h0FFF, 4'h1, 2'h0, 1'b0);
		idx(8'h88, 8'hFE, 8'h00, 16'h0FFE, 4'h1, 2'h1, 1'b0);
		idx(8'h89, 8'h01, 8'h00, 16'h1100, 4'h4, 2'h2, 1'b0);
		idx(8'h86, 8'h00, 8'h00, 16'h0F80, 4'h1, 2'h0, 1'b0);
		idx(8'h85, 8'h00, 8'h00, 16'h1005, 4'h1, 2'h0, 1'b0);
		idx(8'h8B, 8'h00, 8'h00, 16'h9005, 4'h4, 2'h0, 1'b0);
		idx(8'h80, 8'h00, 8'h00, 16'h1000, 4'h2, 2'h0, 1'b1);
		chk("pval", 16'h1001, result.ptr_value);
		idx(8'h83, 8'h00, 8'h00, 16'h0FFE, 4'h3, 2'h0, 1'b1);
		idx(8'h81, 8'h00, 8'h00, 16'h1000, 4'h3, 2'h0, 1'b1);
		chk("pval2", 16'h1002, result.ptr_value);
		idx(8'h82, 8'h00, 8'h00, 16'h0FFF, 4'h2, 2'h0, 1'b1);
		idx(8'h8C, 8'h10, 8'h00, 16'h0312, 4'h1, 2'h1, 1'b0);
		idx(8'h8D, 8'h01, 8'h00, 16'h0403, 4'h5, 2'h2, 1'b0);
		idx(8'h94, 8'h00, 8'h00, 16'hBEEF, 4'h3, 2'h0, 1'b0);
		idx(8'h98, 8'h00, 8'h00, 16'hBEEF, 4'h4, 2'h1, 1'b0);
		idx(8'h9F, 8'h12, 8'h00, 16'hCAFE, 4'h5, 2'h2, 1'b0);
		mem.m[16'h0300] = 8'h87;
		go(EAU_MODE_INDEXED, 16'h0300);
		chk("undef", 1, result.undefined);
		mem.m[16'h0300] = 8'h90;
		go(EAU_MODE_INDEXED, 16'h0300);
		chk("undef_ind", 1, result.undefined);
		chk("undef_pwr", 0, result.ptr_write);
	endtask

	initial begin
		error_cnt = 0;
		comparisons = 0;
		reset = 1'b1;
		start = 1'b0;
		mode = EAU_MODE_EXTENDED;
		operand_addr = 16'h0000;
		page_base_load = 1'b0;
		page_base_value = 8'h00;
		lat = 2'h0;
		ptrs = {16'h1000, 16'h2000, 16'h3000, 16'h4000, 8'h80, 8'h05};
		repeat (6) @(posedge clk);
		#1 reset = 1'b0;
		t_direct;
		t_ext_reg;
		t_indexed;
		final_report;
	end

	// Whole run needs well under two thousand cycles.
	initial begin
		#200000;
		error_cnt++;
		final_report;
	end
endmodule // testbench

`default_nettype wire
